// *** src/fdm_flash_ctrl.sv ***
// Mode, converter protection and flash ramp control of the flash driver, with an APB register slave.
// How it works
// - Voltage output mode follows either brightness bit 2 or the mode input pin.
// - Level select bit 1 of configuration picks 5V when set, 4.5V when clear.
// - LED sources stay available in voltage output mode, never forced off.
// - Input above target output in voltage mode: stop switching, high-side fully on.
// - Light-load comparator enabled and load light: pulse-frequency operation.
// - Output at 5.6V turns both switches off until it drops below 5.4V.
// - Two select bits at positions 5 and 6 of duration register choose current limit.
// - Reaching the limit stops switching for the rest of the switching cycle.
// - Output below about 2.3V: stop switching, high side acts as 350mA source.
// - Flash level is a four-bit field at bits 6..3 of flash brightness.
// - Flash starts on enable field 1,1 in either brightness register or trigger pin.
// - On flash start both sources step one level per 16us up to the target.
// - Configuration bit 0 set disables light-load comparator; always off outside voltage mode.
// - After pass gave way to switching, switching holds until shutdown and re-enable.
module fdm_flash_ctrl
  import fdm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        voltage_mode_input_i,
  input  wire logic        strobe_i,
  input  wire logic        vin_above_vout_i,
  input  wire logic        light_load_i,
  input  wire logic        ovp_trip_i,
  input  wire logic        ovp_release_i,
  input  wire logic        ilim_reached_i,
  input  wire logic        cycle_start_i,
  input  wire logic        vout_short_i,
  output logic             vm_active_o,
  output logic             output_level_select_o,
  output logic             light_load_en_o,
  output logic             pfm_o,
  output logic             ls_switch_en_o,
  output logic             hs_full_on_o,
  output logic             hs_csrc_o,
  output logic [1:0]       ilim_sel_o,
  output logic             flash_active_o,
  output logic [3:0]       led_level_o,
  output logic             led_source_a_en_o,
  output logic             led_source_b_en_o
);
  logic [7:0] torch_q, flash_q, dur_q, cfg1_q;
  logic       vm_src, flash_req, active, lle;
  logic       ovp_q, blk_q, blk_d, stick_q;
  logic [8:0] tmr_q;
  logic [3:0] target;
  fdm_conv_t  cv_q, cv_d;

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a == FDM_TORCH_ADDR) || (a == FDM_FLASH_ADDR) || (a == FDM_DUR_ADDR) ||
              (a == FDM_CFG1_ADDR) || (a == FDM_STAT_ADDR);
  endfunction

  // Flash enable code of one brightness register.
  function automatic logic en_flash(input logic [7:0] r);
    en_flash = (r[1:0] == FDM_EN_FLASH);
  endfunction

  logic acc, wr_done;
  assign acc     = psel_i && penable_i;
  assign wr_done = acc && pready_o && pwrite_i;

  // Answer comes one cycle into the access phase.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc && !pready_o;
      pslverr_o <= acc && !pready_o && !map_hit(paddr_i);
      prdata_o  <= 32'h0000_0000;
      if (acc && !pready_o && !pwrite_i) begin
        case (paddr_i)
          FDM_TORCH_ADDR: prdata_o <= {24'h00_0000, torch_q};
          FDM_FLASH_ADDR: prdata_o <= {24'h00_0000, flash_q};
          FDM_DUR_ADDR:   prdata_o <= {24'h00_0000, dur_q};
          FDM_CFG1_ADDR:  prdata_o <= {24'h00_0000, cfg1_q};
          FDM_STAT_ADDR:  prdata_o <= {24'h00_0000, stick_q, ovp_q, flash_active_o, led_level_o, cv_q == FDM_CV_PASS};
          default:        prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A write lands at the edge that completes the access phase.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      torch_q <= FDM_REG_RST;
      flash_q <= FDM_REG_RST;
      dur_q   <= FDM_REG_RST;
      cfg1_q  <= FDM_REG_RST;
    end else if (wr_done) begin
      case (paddr_i)
        FDM_TORCH_ADDR: torch_q <= pwdata_i[7:0];
        FDM_FLASH_ADDR: flash_q <= pwdata_i[7:0];
        FDM_DUR_ADDR:   dur_q   <= pwdata_i[7:0];
        FDM_CFG1_ADDR:  cfg1_q  <= pwdata_i[7:0];
        default:        ;
      endcase
    end
  end

  assign vm_src    = torch_q[FDM_VM_BIT] || flash_q[FDM_VM_BIT] || voltage_mode_input_i;
  assign flash_req = en_flash(torch_q) || en_flash(flash_q) || strobe_i;
  assign active    = vm_src || flash_req;
  assign lle       = vm_src && !cfg1_q[FDM_LLD_BIT];
  assign target    = flash_q[FDM_LVL_MSB:FDM_LVL_LSB];

  // Over-voltage latch with hysteresis; a new trip wins over release.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovp_q <= 1'b0;
    end else if (ovp_trip_i) begin
      ovp_q <= 1'b1;
    end else if (ovp_release_i) begin
      ovp_q <= 1'b0;
    end
  end

  // Current limit blanks switching until the next cycle starts.
  assign blk_d = ilim_reached_i || (blk_q && !cycle_start_i);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blk_q <= 1'b0;
    end else begin
      blk_q <= blk_d;
    end
  end

  // One-time decision from pass to switching, held until the block goes idle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stick_q <= 1'b0;
    end else if (!active) begin
      stick_q <= 1'b0;
    end else if (cv_q == FDM_CV_PASS && !vin_above_vout_i) begin
      stick_q <= 1'b1;
    end
  end

  // Converter state priority: off, short, over-voltage, pass, light load, boost.
  always_comb begin
    if (!active) begin
      cv_d = FDM_CV_OFF;
    end else if (vout_short_i) begin
      cv_d = FDM_CV_SHORT;
    end else if (ovp_trip_i || (ovp_q && !ovp_release_i)) begin
      cv_d = FDM_CV_OVP;
    end else if (vin_above_vout_i && !stick_q && !(cv_q == FDM_CV_PASS && !vin_above_vout_i)) begin
      cv_d = FDM_CV_PASS;
    end else if (lle && light_load_i) begin
      cv_d = FDM_CV_PFM;
    end else begin
      cv_d = FDM_CV_BOOST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cv_q           <= FDM_CV_OFF;
      ls_switch_en_o <= 1'b0;
      hs_full_on_o   <= 1'b0;
      hs_csrc_o      <= 1'b0;
      pfm_o          <= 1'b0;
    end else begin
      cv_q           <= cv_d;
      ls_switch_en_o <= 1'b0;
      hs_full_on_o   <= 1'b0;
      hs_csrc_o      <= 1'b0;
      pfm_o          <= 1'b0;
      case (cv_d)
        FDM_CV_PASS:  hs_full_on_o <= 1'b1;
        FDM_CV_BOOST: ls_switch_en_o <= !blk_d;
        FDM_CV_PFM: begin
          ls_switch_en_o <= !blk_d;
          pfm_o          <= 1'b1;
        end
        FDM_CV_SHORT: hs_csrc_o <= 1'b1;
        FDM_CV_OVP:   ;
        FDM_CV_OFF:   ;
        default:      ;
      endcase
    end
  end

  // Mode and select outputs are registered copies of their sources.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vm_active_o           <= 1'b0;
      output_level_select_o <= 1'b0;
      light_load_en_o       <= 1'b0;
      ilim_sel_o            <= FDM_ILIM_1A0;
    end else begin
      vm_active_o           <= vm_src;
      output_level_select_o <= cfg1_q[FDM_OLS_BIT];
      light_load_en_o       <= lle;
      ilim_sel_o            <= {dur_q[FDM_CL_HI], dur_q[FDM_CL_LO]};
    end
  end

  // Flash ramp: level 0 at start, one step per ramp interval up to the target.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_active_o    <= 1'b0;
      led_level_o       <= 4'h0;
      tmr_q             <= 9'h000;
      led_source_a_en_o <= 1'b0;
      led_source_b_en_o <= 1'b0;
    end else begin
      flash_active_o    <= flash_req;
      led_source_a_en_o <= flash_req;
      led_source_b_en_o <= flash_req;
      if (!flash_req || !flash_active_o) begin
        led_level_o <= 4'h0;
        tmr_q       <= 9'h000;
      end else if (led_level_o > target) begin
        led_level_o <= target;
        tmr_q       <= 9'h000;
      end else if (led_level_o == target) begin
        tmr_q <= 9'h000;
      end else if (tmr_q == FDM_RAMP_LAST) begin
        led_level_o <= led_level_o + 4'h1;
        tmr_q       <= 9'h000;
      end else begin
        tmr_q <= tmr_q + 9'h001;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_flash_go;
    !flash_active_o ##1 flash_req;
  endsequence
  sequence s_step_up;
    flash_active_o && $past(flash_active_o) && (led_level_o > $past(led_level_o)) && (led_level_o <= target);
  endsequence

  a_vm_follow: assert property (vm_active_o == $past(vm_src))
    else $error("Voltage mode output does not follow its sources.");
  a_ols_follow: assert property (output_level_select_o == $past(cfg1_q[FDM_OLS_BIT]))
    else $error("Output level select does not follow configuration.");
  a_ovp_cutoff: assert property (active && !vout_short_i && ovp_trip_i |=> !ls_switch_en_o && !hs_full_on_o)
    else $error("Switches not off after over-voltage trip.");
  a_ilim_blank: assert property (active && ilim_reached_i |=> !ls_switch_en_o)
    else $error("Switching continued after current limit.");
  a_short_csrc: assert property (active && vout_short_i |=> hs_csrc_o && !ls_switch_en_o && !hs_full_on_o)
    else $error("Short circuit did not select current source.");
  a_pass_stick: assert property (stick_q && active && $past(active) |=> !hs_full_on_o)
    else $error("Pass operation re-entered after switching decision.");
  a_lld_outside: assert property (!vm_active_o |-> !pfm_o)
    else $error("Pulse-frequency operation outside voltage mode.");
  a_flash_start: assert property (s_flash_go |=> flash_active_o && led_level_o == 4'h0)
    else $error("Flash did not start at the lowest level.");
  a_ramp_step: assert property (s_step_up |-> led_level_o == $past(led_level_o) + 4'h1 && $past(tmr_q) == FDM_RAMP_LAST)
    else $error("Flash ramp stepped wrongly.");
  a_ilim_code: assert property (ilim_sel_o == $past({dur_q[FDM_CL_HI], dur_q[FDM_CL_LO]}))
    else $error("Current limit select does not follow register.");
  a_src_avail: assert property (vm_active_o && flash_active_o |-> led_source_a_en_o && led_source_b_en_o)
    else $error("LED sources forced off in voltage mode.");

  // Converter, protection and ramp checks on each decision branch.
  sequence s_pass_cond;
    active && !vout_short_i && !ovp_trip_i && !ovp_q && vin_above_vout_i && !stick_q;
  endsequence
  sequence s_pfm_cond;
    active && !vout_short_i && !ovp_trip_i && !ovp_q && !vin_above_vout_i && lle && light_load_i;
  endsequence
  sequence s_ovp_held;
    active && !vout_short_i && ovp_q && !ovp_release_i;
  endsequence
  sequence s_blank_end;
    blk_q && cycle_start_i && !ilim_reached_i && (cv_d == FDM_CV_BOOST);
  endsequence
  sequence s_ramp_wait;
    flash_active_o && flash_req && (led_level_o < target) && (tmr_q != FDM_RAMP_LAST);
  endsequence

  a_vm_pin: assert property (voltage_mode_input_i |=> vm_active_o)
    else $error("Voltage mode input did not enable voltage output mode.");
  a_src_enable: assert property (flash_req |=> led_source_a_en_o && led_source_b_en_o)
    else $error("LED sources not enabled on request.");
  a_pass_on: assert property (s_pass_cond |=> hs_full_on_o && !ls_switch_en_o)
    else $error("Pass operation not entered.");
  a_hs_exclusive: assert property (!(hs_full_on_o && ls_switch_en_o))
    else $error("Switching while high side is fully on.");
  a_pfm_enter: assert property (s_pfm_cond |=> pfm_o)
    else $error("Pulse-frequency operation not entered at light load.");
  a_ovp_hold: assert property (s_ovp_held |=> !ls_switch_en_o && !hs_full_on_o)
    else $error("Switching resumed before over-voltage release.");
  a_ilim_resume: assert property (s_blank_end |=> ls_switch_en_o)
    else $error("Switching did not resume at the next cycle.");
  a_flash_stop: assert property (!flash_req |=> !flash_active_o && led_level_o == 4'h0 && !led_source_a_en_o)
    else $error("Flash did not stop when request dropped.");
  a_ramp_hold: assert property (s_ramp_wait |=> $stable(led_level_o))
    else $error("Flash level stepped before the ramp interval ended.");
  a_lle_cfg: assert property (cfg1_q[FDM_LLD_BIT] |=> !light_load_en_o)
    else $error("Light-load comparator enabled although disabled by configuration.");
  a_stick_set: assert property (active && cv_q == FDM_CV_PASS && !vin_above_vout_i |=> stick_q)
    else $error("Switching decision not latched after pass ended.");
endmodule

// *** src/fdm_pkg.sv ***
// Package with register map, field positions and timing constants of the flash driver control.
package fdm_pkg;
  localparam logic [7:0] FDM_TORCH_ADDR = 8'ha0;
  localparam logic [7:0] FDM_FLASH_ADDR = 8'hb0;
  localparam logic [7:0] FDM_DUR_ADDR   = 8'hc0;
  localparam logic [7:0] FDM_CFG1_ADDR  = 8'he0;
  localparam logic [7:0] FDM_STAT_ADDR  = 8'hf0;
  localparam logic [7:0] FDM_REG_RST    = 8'h00;
  localparam int FDM_VM_BIT   = 2;
  localparam int FDM_OLS_BIT  = 1;
  localparam int FDM_LLD_BIT  = 0;
  localparam int FDM_CL_LO    = 5;
  localparam int FDM_CL_HI    = 6;
  localparam int FDM_LVL_LSB  = 3;
  localparam int FDM_LVL_MSB  = 6;
  localparam logic [1:0] FDM_EN_FLASH = 2'h3;
  localparam int FDM_RAMP_NS  = 16000;
  localparam int FDM_CLK_NS   = 50;
  localparam int FDM_RAMP_CYC = (FDM_RAMP_NS + FDM_CLK_NS - 1) / FDM_CLK_NS;
  localparam logic [8:0] FDM_RAMP_LAST = 9'(FDM_RAMP_CYC - 1);
  typedef enum logic [1:0] {
    FDM_ILIM_1A0 = 2'b00,
    FDM_ILIM_1A5 = 2'b01,
    FDM_ILIM_2A0 = 2'b10,
    FDM_ILIM_2A5 = 2'b11
  } fdm_ilim_t;
  typedef enum logic [2:0] {
    FDM_CV_OFF   = 3'b000,
    FDM_CV_PASS  = 3'b001,
    FDM_CV_BOOST = 3'b010,
    FDM_CV_PFM   = 3'b011,
    FDM_CV_OVP   = 3'b100,
    FDM_CV_SHORT = 3'b101
  } fdm_conv_t;
endpackage

// *** bench/fdm_host.sv ***
// Host model: APB master that moves register transfers into the flash driver control.
module fdm_host (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o    = 1'h0,
  output logic             penable_o = 1'h0,
  output logic             pwrite_o  = 1'h0,
  output logic [7:0]       paddr_o   = 8'h00,
  output logic [31:0]      pwdata_o  = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released address and data lines show the inverse so that stale values are never taken for valid ones.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o    <= 1'h1;
    penable_o <= 1'h0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'h1;
    do @(posedge clk_i); while (pready_i !== 1'h1);
    r = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'h0;
    penable_o <= 1'h0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule

// *** bench/tb.sv ***
// Testbench: drives pins and APB traffic into the flash driver control and checks the sampled outputs and read results.
module tb
  import fdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'h0, rst_b_i = 1'h0, er;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, wd;
  logic        voltage_mode_input_i = 1'h0, strobe_i = 1'h0, vin_above_vout_i = 1'h0, light_load_i = 1'h0;
  logic        ovp_trip_i = 1'h0, ovp_release_i = 1'h0, ilim_reached_i = 1'h0, cycle_start_i = 1'h0;
  logic        vout_short_i = 1'h0, vm_active_o, output_level_select_o, light_load_en_o, pfm_o, ls_switch_en_o;
  logic        hs_full_on_o, hs_csrc_o, flash_active_o, led_source_a_en_o, led_source_b_en_o;
  logic [1:0]  ilim_sel_o;
  logic [3:0]  led_level_o;
  int          failures = 0, compares = 0;
  int          tgt, ramp_q[$], shadow[int];
  fdm_ilim_t   lim[4] = '{FDM_ILIM_1A0, FDM_ILIM_1A5, FDM_ILIM_2A0, FDM_ILIM_2A5};
  logic [7:0]  regs[5] = '{FDM_TORCH_ADDR, FDM_FLASH_ADDR, FDM_DUR_ADDR, FDM_CFG1_ADDR, FDM_STAT_ADDR};
  always #25 clk_i = ~clk_i;
  fdm_flash_ctrl fdm_flash_ctrl_inst (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o, .voltage_mode_input_i, .strobe_i, .vin_above_vout_i, .light_load_i,
    .ovp_trip_i, .ovp_release_i, .ilim_reached_i, .cycle_start_i, .vout_short_i, .vm_active_o,
    .output_level_select_o, .light_load_en_o, .pfm_o, .ls_switch_en_o, .hs_full_on_o, .hs_csrc_o, .ilim_sel_o,
    .flash_active_o, .led_level_o, .led_source_a_en_o, .led_source_b_en_o);
  fdm_host fdm_host_inst (.clk_i, .pready_i(pready_o), .prdata_i(prdata_o), .pslverr_i(pslverr_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Outputs are looked at on the falling edge, clear of the edge that updates them.
  task automatic look(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fdm_host_inst.xfer(1'h1, a, d, rd, er);
    shadow[a] = int'(d[7:0]);
  endtask
  task automatic finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12000) @(posedge clk_i);
    failures++;
    finish_test();
  end
  initial begin
    wd = $urandom(32'h00888cbd);
    tick(8);
    rst_b_i <= 1'h1;
    look(1);
    chk({vm_active_o, ls_switch_en_o, hs_full_on_o, flash_active_o, led_level_o}, 32'h0);
    foreach (regs[i]) begin
      fdm_host_inst.xfer(1'h0, regs[i], 32'h0, rd, er);
      chk(rd, {24'h00_0000, FDM_REG_RST});
      chk(er, 1'h0);
    end
    fdm_host_inst.xfer(1'h0, 8'h10, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk(er, 1'h1);
    wr(FDM_TORCH_ADDR, 32'h4);
    look(2);
    chk({vm_active_o, light_load_en_o, output_level_select_o, ls_switch_en_o, hs_full_on_o}, 5'h1a);
    tick(1);
    light_load_i <= 1'h1;
    look(2);
    chk(pfm_o, 1'h1);
    wr(FDM_CFG1_ADDR, 32'h3);
    look(2);
    chk({output_level_select_o, light_load_en_o, pfm_o}, 3'h4);
    wr(FDM_CFG1_ADDR, 32'h0);
    light_load_i <= 1'h0;
    look(2);
    chk({output_level_select_o, light_load_en_o, ls_switch_en_o}, 3'h3);
    tick(1);
    vin_above_vout_i <= 1'h1;
    look(2);
    chk({hs_full_on_o, ls_switch_en_o}, 2'h2);
    tick(1);
    vin_above_vout_i <= 1'h0;
    look(2);
    tick(1);
    vin_above_vout_i <= 1'h1;
    look(2);
    chk({hs_full_on_o, ls_switch_en_o}, 2'h1);
    wr(FDM_TORCH_ADDR, 32'h0);
    look(2);
    chk({vm_active_o, light_load_en_o}, 2'h0);
    tick(1);
    voltage_mode_input_i <= 1'h1;
    look(2);
    chk({vm_active_o, hs_full_on_o}, 2'h3);
    tick(1);
    vin_above_vout_i <= 1'h0;
    ovp_trip_i <= 1'h1;
    tick(1);
    ovp_trip_i <= 1'h0;
    look(4);
    chk({ls_switch_en_o, hs_full_on_o}, 2'h0);
    tick(1);
    ovp_release_i <= 1'h1;
    tick(1);
    ovp_release_i <= 1'h0;
    look(2);
    chk(ls_switch_en_o, 1'h1);
    tick(1);
    ilim_reached_i <= 1'h1;
    tick(1);
    ilim_reached_i <= 1'h0;
    look(3);
    chk(ls_switch_en_o, 1'h0);
    tick(1);
    cycle_start_i <= 1'h1;
    tick(1);
    cycle_start_i <= 1'h0;
    look(2);
    chk(ls_switch_en_o, 1'h1);
    tick(1);
    vout_short_i <= 1'h1;
    look(2);
    chk({hs_csrc_o, ls_switch_en_o, hs_full_on_o}, 3'h4);
    tick(1);
    vout_short_i <= 1'h0;
    for (int c = 0; c < 4; c++) begin
      wd = $urandom;
      wd[6:5] = 2'(c);
      wr(FDM_DUR_ADDR, wd);
      look(2);
      chk(ilim_sel_o, lim[c]);
      fdm_host_inst.xfer(1'h0, FDM_DUR_ADDR, 32'h0, rd, er);
      chk(rd, shadow[FDM_DUR_ADDR]);
    end
    voltage_mode_input_i <= 1'h0;
    wr(FDM_FLASH_ADDR, 32'h4f);
    look(1);
    chk({flash_active_o, led_source_a_en_o, led_source_b_en_o, led_level_o}, 7'h70);
    look(160);
    tgt = (32'h4f >> FDM_LVL_LSB) & 32'hf;
    for (int k = 1; k <= 10; k++) ramp_q.push_back((k > tgt) ? tgt : k);
    while (ramp_q.size() > 0) begin
      look(320);
      chk(led_level_o, ramp_q.pop_front());
    end
    chk({vm_active_o, led_source_a_en_o, led_source_b_en_o}, 3'h7);
    fdm_host_inst.xfer(1'h0, FDM_STAT_ADDR, 32'h0, rd, er);
    chk(rd[6:0], 7'h32);
    wr(FDM_FLASH_ADDR, 32'h48);
    look(2);
    chk({flash_active_o, led_source_a_en_o, led_level_o}, 6'h0);
    tick(1);
    strobe_i <= 1'h1;
    look(2);
    chk({flash_active_o, led_source_a_en_o, led_source_b_en_o}, 3'h7);
    tick(1);
    strobe_i <= 1'h0;
    look(2);
    chk(flash_active_o, 1'h0);
    finish_test();
  end
endmodule
